/* rtl/qpio_pkg.sv */
/*
 * constants and carriers for the four-port parallel i/o block.
 * assumes one core clock; pin levels resolved by the outside world.
 */
package qpio_pkg;
	// ****************************************
	// sizes and select codes
	// ****************************************
	localparam int        PORT_W    = 8;
	localparam logic [1:0] SEL_P0   = 2'h0;
	localparam logic [1:0] SEL_P1   = 2'h1;
	localparam logic [1:0] SEL_P2   = 2'h2;
	localparam logic [1:0] SEL_P3   = 2'h3;
	localparam logic [7:0] LATCH_RST = 8'h00ff;
	localparam logic [7:0] ALL_ONES  = 8'h00ff;
	localparam int        P1_DIG_LO = 2;
	// ****************************************
	// timing
	// ****************************************
	localparam int STRONG_PU_PERIODS = 2;
	localparam int STRONG_PU_CYCLES  = (STRONG_PU_PERIODS < 1) ? 1 : STRONG_PU_PERIODS;
	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic       wr;
		logic       rd_latch;
		logic       rd_pin;
		logic [1:0] sel;
		logic [7:0] wdata;
	} sfr_req_s;
	typedef struct packed {
		logic       active;
		logic [7:0] ad;
		logic       ad_oe;
		logic [7:0] addr_hi;
	} ext_bus_s;
endpackage : qpio_pkg

/* rtl/quad_parallel_port_io.sv */
/*
 * four 8-bit parallel ports: latches, pin read-back, alternate functions,
 * external memory bus drive. assumes pins resolved externally with pull-ups.
 */
`timescale 1ns/1ps
module quad_parallel_port_io import qpio_pkg::*; (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// special function register access
	input  wire sfr_req_s   sfr_i,
	output logic [7:0]      sfr_rdata_o,
	// external memory bus
	input  wire ext_bus_s   ext_i,
	// port 0 pins
	input  wire logic [7:0] p0_in_i,
	output logic [7:0]      p0_out_o,
	output logic [7:0]      p0_oe_o,
	// port 1 pins
	input  wire logic [7:0] p1_in_i,
	output logic [1:0]      p1_out_o,
	output logic [1:0]      p1_oe_o,
	output logic [1:0]      p1_strong_pu_o,
	output logic [5:0]      p1_analog_sel_o,
	// port 2 pins
	input  wire logic [7:0] p2_in_i,
	output logic [7:0]      p2_out_o,
	output logic [7:0]      p2_oe_o,
	output logic [7:0]      p2_strong_pu_o,
	// port 3 pins
	input  wire logic [7:0] p3_in_i,
	output logic [7:0]      p3_out_o,
	output logic [7:0]      p3_oe_o,
	output logic [7:0]      p3_strong_pu_o,
	// port 1 alternate functions
	input  wire logic [1:0] pwm_route_i,
	input  wire logic       pulse_width_out_a_i,
	input  wire logic       pulse_width_out_b_i,
	output logic            timer2_count_input_o,
	output logic            timer2_capture_trigger_o,
	// port 3 alternate functions, and port 0 external data input
	input  wire logic [7:0] p3_alt_en_i,
	input  wire logic [7:0] p3_alt_out_i,
	output logic [7:0]      p3_alt_in_o,
	output logic [7:0]      ext_data_in_o
);
	// ****************************************
	// latches
	// ****************************************
	logic [7:0] latch0;
	logic [7:0] latch1;
	logic [7:0] latch2;
	logic [7:0] latch3;
	logic [31:0] pin_meta;
	logic [31:0] pin_sync;
	logic [17:0] pu_d1;
	logic [17:0] pu_d2;

	wire wr0 = sfr_i.wr && (sfr_i.sel == SEL_P0);
	wire wr1 = sfr_i.wr && (sfr_i.sel == SEL_P1);
	wire wr2 = sfr_i.wr && (sfr_i.sel == SEL_P2);
	wire wr3 = sfr_i.wr && (sfr_i.sel == SEL_P3);

	wire [7:0] next_latch0 = ext_i.active ? ALL_ONES : (wr0 ? sfr_i.wdata : latch0);
	wire [7:0] next_latch1 = wr1 ? sfr_i.wdata : latch1;
	wire [7:0] next_latch2 = wr2 ? sfr_i.wdata : latch2;
	wire [7:0] next_latch3 = wr3 ? sfr_i.wdata : latch3;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			latch0 <= LATCH_RST;
			latch1 <= LATCH_RST;
			latch2 <= LATCH_RST;
			latch3 <= LATCH_RST;
		end else begin
			latch0 <= next_latch0;
			latch1 <= next_latch1;
			latch2 <= next_latch2;
			latch3 <= next_latch3;
		end
	end

	chk_p0_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr0 && !ext_i.active |=> latch0 == $past(sfr_i.wdata))
		else $error("port 0 latch write lost");
	chk_p2_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr2 |=> latch2 == $past(sfr_i.wdata))
		else $error("port 2 latch write lost");

	// ****************************************
	// pin synchronisers
	// ****************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {p3_in_i, p2_in_i, p1_in_i, p0_in_i};
			pin_sync <= pin_meta;
		end
	end

	wire [7:0] pin0 = pin_sync[7:0];
	wire [7:0] pin1 = pin_sync[15:8];
	wire [7:0] pin2 = pin_sync[23:16];
	wire [7:0] pin3 = pin_sync[31:24];

	// ****************************************
	// read-back
	// ****************************************
	function automatic logic [7:0] pick(input logic [1:0] s, input logic [31:0] v);
		pick = v[8*s +: 8];
	endfunction : pick

	wire [7:0] rd_latch_val = pick(sfr_i.sel, {latch3, latch2, latch1, latch0});
	wire [7:0] rd_pin_val   = pick(sfr_i.sel, pin_sync);
	wire [7:0] next_rdata   = sfr_i.rd_latch ? rd_latch_val :
		(sfr_i.rd_pin ? rd_pin_val : sfr_rdata_o);

	chk_rd_pin: assert property (@(posedge clk_i) disable iff (rst_i)
		sfr_i.rd_pin && !sfr_i.rd_latch && sfr_i.sel == SEL_P3 |=> sfr_rdata_o == $past(pin3))
		else $error("read-pin data wrong");
	chk_rd_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!sfr_i.rd_latch && !sfr_i.rd_pin |=> $stable(sfr_rdata_o))
		else $error("read data changed without a read");

	// ****************************************
	// drive values
	// ****************************************
	wire [1:0] pwm_val = {pulse_width_out_b_i, pulse_width_out_a_i};
	wire [1:0] p1v;
	wire [7:0] p3v;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_p1
			assign p1v[gi] = pwm_route_i[gi] ? pwm_val[gi] : latch1[gi];
		end
		for (gi = 0; gi < 8; gi++) begin : g_p3
			assign p3v[gi] = latch3[gi] & (p3_alt_en_i[gi] ? p3_alt_out_i[gi] : 1'b1);
		end
	endgenerate

	wire [7:0] next_p0_out = ext_i.active ? ext_i.ad : 8'h0000;
	wire [7:0] next_p0_oe  = ext_i.active ? {8{ext_i.ad_oe}} : ~latch0;
	wire [7:0] next_p2_out = ext_i.active ? ext_i.addr_hi : 8'h0000;
	wire [7:0] next_p2_oe  = ext_i.active ? ALL_ONES : ~latch2;
	wire [1:0] next_p1_oe  = ~p1v;
	wire [7:0] next_p3_oe  = ~p3v;

	chk_p1_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		!pwm_route_i[1] |=> p1_oe_o[1] == !$past(latch1[1]))
		else $error("port 1 pin drive wrong");
	chk_pwm_b_override: assert property (@(posedge clk_i) disable iff (rst_i)
		pwm_route_i[1] |=> p1_oe_o[1] == !$past(pulse_width_out_b_i))
		else $error("second pwm does not override latch");
	chk_p2_general: assert property (@(posedge clk_i) disable iff (rst_i)
		!ext_i.active |=> p2_oe_o == ~$past(latch2) && p2_out_o == 8'h00)
		else $error("port 2 general drive wrong");
	chk_p2_ext_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		ext_i.active |=> p2_oe_o == ALL_ONES)
		else $error("port 2 not push-pull in external mode");
	chk_p0_ext_float: assert property (@(posedge clk_i) disable iff (rst_i)
		ext_i.active && !ext_i.ad_oe |=> p0_oe_o == 8'h00)
		else $error("port 0 driven while bus released");
	chk_p3_general: assert property (@(posedge clk_i) disable iff (rst_i)
		p3_alt_en_i == 8'h00 |=> p3_oe_o == ~$past(latch3) && p3_out_o == 8'h00)
		else $error("port 3 general drive wrong");
	chk_p3_alt_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		latch3[1] && p3_alt_en_i[1] |=> p3_oe_o[1] == !$past(p3_alt_out_i[1]))
		else $error("port 3 peripheral drive wrong");

	// pulled-up pins: strong pull-up while value rose within the last periods
	wire [17:0] pu_v = {p3v, ext_i.active ? 8'h0000 : latch2, p1v};
	wire [17:0] next_pu = pu_v & (pu_d1 | pu_d2);

	chk_strong_limit: assert property (@(posedge clk_i) disable iff (rst_i)
		(p3_strong_pu_o & $past(p3_strong_pu_o) & $past(p3_strong_pu_o, 2)) == 8'h00)
		else $error("strong pull-up longer than two cycles");
	chk_strong_p3: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(p3v[7]) ##1 p3v[7] |-> p3_strong_pu_o[7] ##1 p3_strong_pu_o[7] ##1 !p3_strong_pu_o[7])
		else $error("port 3 strong pull-up pulse wrong");
	chk_strong_p1: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(p1v[1]) ##1 p1v[1] |-> p1_strong_pu_o[1] ##1 p1_strong_pu_o[1] ##1 !p1_strong_pu_o[1])
		else $error("port 1 strong pull-up pulse wrong");

	// alternate inputs, stuck at zero unless the latch holds one
	wire        next_t2c = pin1[0] & latch1[0];
	wire        next_t2x = pin1[1] & latch1[1];
	wire [7:0]  next_alt = pin3 & latch3;

	chk_t2_count_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!latch1[0] |=> !timer2_count_input_o)
		else $error("timer-2 count input not gated");
	chk_t2_count_pass: assert property (@(posedge clk_i) disable iff (rst_i)
		latch1[0] |=> timer2_count_input_o == $past(pin1[0]))
		else $error("timer-2 count input lost");
	chk_p3_alt_in: assert property (@(posedge clk_i) disable iff (rst_i)
		latch3[0] |=> p3_alt_in_o[0] == $past(pin3[0]))
		else $error("port 3 receive input lost");
	chk_ext_din: assert property (@(posedge clk_i) disable iff (rst_i)
		ext_i.active |=> ext_data_in_o == $past(pin0))
		else $error("external data input wrong");
	chk_p1_analog: assert property (@(posedge clk_i) disable iff (rst_i)
		wr1 |=> ##1 p1_analog_sel_o == $past(sfr_i.wdata[7:P1_DIG_LO], 2))
		else $error("analog select wrong");

	// ****************************************
	// output registers
	// ****************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sfr_rdata_o              <= '0;
			p0_out_o                 <= '0;
			p0_oe_o                  <= '0;
			p1_out_o                 <= '0;
			p1_oe_o                  <= '0;
			p1_strong_pu_o           <= '0;
			p1_analog_sel_o          <= '1;
			p2_out_o                 <= '0;
			p2_oe_o                  <= '0;
			p2_strong_pu_o           <= '0;
			p3_out_o                 <= '0;
			p3_oe_o                  <= '0;
			p3_strong_pu_o           <= '0;
			timer2_count_input_o     <= '0;
			timer2_capture_trigger_o <= '0;
			p3_alt_in_o              <= '0;
			ext_data_in_o            <= '0;
			pu_d1                    <= '0;
			pu_d2                    <= '0;
		end else begin
			sfr_rdata_o              <= next_rdata;
			p0_out_o                 <= next_p0_out;
			p0_oe_o                  <= next_p0_oe;
			p1_out_o                 <= '0;
			p1_oe_o                  <= next_p1_oe;
			p1_strong_pu_o           <= next_pu[1:0];
			p1_analog_sel_o          <= latch1[7:P1_DIG_LO];
			p2_out_o                 <= next_p2_out;
			p2_oe_o                  <= next_p2_oe;
			p2_strong_pu_o           <= next_pu[9:2];
			p3_out_o                 <= '0;
			p3_oe_o                  <= next_p3_oe;
			p3_strong_pu_o           <= next_pu[17:10];
			timer2_count_input_o     <= next_t2c;
			timer2_capture_trigger_o <= next_t2x;
			p3_alt_in_o              <= next_alt;
			ext_data_in_o            <= pin0;
			pu_d1                    <= ~pu_v;
			pu_d2                    <= pu_d1;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	chk_p0_ext_ones: assert property (@(posedge clk_i) disable iff (rst_i)
		ext_i.active |=> latch0 == ALL_ONES) else $error("port 0 latch not set by external access");
	chk_p0_open_drain: assert property (@(posedge clk_i) disable iff (rst_i)
		!ext_i.active |=> p0_oe_o == ~$past(latch0) && p0_out_o == 8'h0000)
		else $error("port 0 general drive wrong");
	chk_p0_ext_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		ext_i.active && ext_i.ad_oe |=> p0_oe_o == ALL_ONES && p0_out_o == $past(ext_i.ad))
		else $error("port 0 bus drive wrong");
	chk_latch_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr1 |=> latch1 == $past(sfr_i.wdata)) else $error("latch write lost");
	chk_read_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		sfr_i.rd_latch && sfr_i.sel == SEL_P2 && !wr2 ##1 !wr2 |-> ##1 sfr_rdata_o == latch2)
		else $error("read latch wrong");
	chk_p2_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		ext_i.active && !wr2 |=> $stable(latch2) && p2_out_o == $past(ext_i.addr_hi))
		else $error("port 2 external mode wrong");
	chk_strong_pu: assert property (@(posedge clk_i) disable iff (rst_i)
		($rose(latch2[0]) && !ext_i.active) ##1 (latch2[0] && !ext_i.active) |->
		p2_strong_pu_o[0] ##1 p2_strong_pu_o[0] ##1 !p2_strong_pu_o[0])
		else $error("strong pull-up length wrong");
	chk_p3_stuck: assert property (@(posedge clk_i) disable iff (rst_i)
		!latch3[2] |=> !p3_alt_in_o[2] && p3_oe_o[2]) else $error("port 3 alternate not held zero");
	chk_pwm_override: assert property (@(posedge clk_i) disable iff (rst_i)
		pwm_route_i[0] |=> p1_oe_o[0] == !$past(pulse_width_out_a_i))
		else $error("pwm does not override latch");
	chk_t2_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!latch1[1] |=> !timer2_capture_trigger_o) else $error("timer-2 trigger not gated");
endmodule : quad_parallel_port_io

/* verif/qpio_pin_model.sv */
/*
 * pin model of the outside world: pull-ups on every pin, external pull-downs.
 * assumes drive outputs of the port block and a pull-down mask from the bench.
 */
`timescale 1ns/1ps
module qpio_pin_model (
	// drive from the block
	input  wire logic [7:0]  p0_out_i,
	input  wire logic [7:0]  p0_oe_i,
	input  wire logic [1:0]  p1_out_i,
	input  wire logic [1:0]  p1_oe_i,
	input  wire logic [7:0]  p2_out_i,
	input  wire logic [7:0]  p2_oe_i,
	input  wire logic [7:0]  p3_out_i,
	input  wire logic [7:0]  p3_oe_i,
	// external pull-downs
	input  wire logic [31:0] ext_low_i,
	// resolved pin levels
	output logic [7:0]       p0_pin_o,
	output logic [7:0]       p1_pin_o,
	output logic [7:0]       p2_pin_o,
	output logic [7:0]       p3_pin_o
);
	// ****************************************
	// released pins go to the pull-up level unless held low by an external pull-down
	// ****************************************
	function automatic logic [7:0] lvl(logic [7:0] o, logic [7:0] oe, logic [7:0] lo);
		return (oe & o) | (~oe & ~lo);
	endfunction : lvl
	assign p0_pin_o = lvl(p0_out_i, p0_oe_i, ext_low_i[7:0]);
	assign p1_pin_o = lvl({6'h00, p1_out_i}, {6'h00, p1_oe_i}, ext_low_i[15:8]);
	assign p2_pin_o = lvl(p2_out_i, p2_oe_i, ext_low_i[23:16]);
	assign p3_pin_o = lvl(p3_out_i, p3_oe_i, ext_low_i[31:24]);
endmodule : qpio_pin_model

/* verif/tb_quad_parallel_port_io.sv */
/*
 * self-checking bench of the four-port block with its pin model.
 * assumes register reads answer one cycle after the strobe edge.
 */
`timescale 1ns/1ps
module tb_quad_parallel_port_io import qpio_pkg::*; ;
	// ****************************************
	// signals
	// ****************************************
	logic clk_i = 0, rst_i = 1, pwm_a, pwm_b, t2c, t2x, rd_q, rd_q2;
	sfr_req_s special_function_register;
	ext_bus_s ext;
	logic [7:0] p0p, p1p, p2p, p3p, rdata, p0o, p0e, p2o, p2e, p2s, p3o, p3e, p3s, p3i, exd, aen, aout, d, m;
	logic [1:0] p1o, p1e, p1s, route;
	logic [5:0] p1a;
	logic [31:0] lo, seed = 32'h0000_0049;
	logic [7:0] expq[$];
	int mismatches = 0, total_checks = 0;
	always #4 clk_i = ~clk_i;
	quad_parallel_port_io dut_u (.clk_i(clk_i), .rst_i(rst_i), .sfr_i(special_function_register), .sfr_rdata_o(rdata), .ext_i(ext),
		.p0_in_i(p0p), .p0_out_o(p0o), .p0_oe_o(p0e), .p1_in_i(p1p), .p1_out_o(p1o), .p1_oe_o(p1e),
		.p1_strong_pu_o(p1s), .p1_analog_sel_o(p1a), .p2_in_i(p2p), .p2_out_o(p2o), .p2_oe_o(p2e),
		.p2_strong_pu_o(p2s), .p3_in_i(p3p), .p3_out_o(p3o), .p3_oe_o(p3e), .p3_strong_pu_o(p3s),
		.pwm_route_i(route), .pulse_width_out_a_i(pwm_a), .pulse_width_out_b_i(pwm_b),
		.timer2_count_input_o(t2c), .timer2_capture_trigger_o(t2x), .p3_alt_en_i(aen),
		.p3_alt_out_i(aout), .p3_alt_in_o(p3i), .ext_data_in_o(exd));
	qpio_pin_model pins_u (.p0_out_i(p0o), .p0_oe_i(p0e), .p1_out_i(p1o), .p1_oe_i(p1e), .p2_out_i(p2o),
		.p2_oe_i(p2e), .p3_out_i(p3o), .p3_oe_i(p3e), .ext_low_i(lo), .p0_pin_o(p0p), .p1_pin_o(p1p),
		.p2_pin_o(p2p), .p3_pin_o(p3p));
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	function automatic logic [7:0] spu(int i);
		return (i == 1) ? {6'h00, p1s} : (i == 2) ? p2s : p3s;
	endfunction : spu
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc
	task automatic wr(logic [1:0] s, logic [7:0] v);
		special_function_register.wr = 1;
		special_function_register.sel = s;
		special_function_register.wdata = v;
		cyc(1);
		special_function_register.wr = 0;
	endtask : wr
	task automatic rd(logic [1:0] s, logic pin, logic [7:0] e);
		special_function_register.rd_latch = !pin;
		special_function_register.rd_pin = pin;
		special_function_register.sel = s;
		expq.push_back(e);
		cyc(1);
		special_function_register.rd_latch = 0;
		special_function_register.rd_pin = 0;
		cyc(1);
	endtask : rd
	task automatic summarize();
		if (mismatches == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize
	// ****************************************
	// read monitor and watchdog
	// ****************************************
	always @(posedge clk_i) begin
		rd_q <= special_function_register.rd_latch | special_function_register.rd_pin;
		rd_q2 <= rd_q;
	end
	always @(negedge clk_i) if (rd_q2 === 1'b1) chk("rdata", rdata, expq.pop_front());
	initial begin
		repeat (3000) @(posedge clk_i);
		mismatches++;
		summarize();
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		special_function_register = '0;
		ext = '0;
		lo = '0;
		route = 0;
		pwm_a = 0;
		pwm_b = 0;
		aen = 0;
		aout = 0;
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 0;
		cyc(1);
		for (int i = 0; i < 4; i++) rd(i[1:0], 0, LATCH_RST);
		chk("analog", {2'b00, p1a}, 8'h3f);
		chk("oe_rst", p0e | p2e | p3e, 8'h00);
		chk("out_low", {6'h00, p1o} | p3o, 8'h00);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			d = seed[7:0];
			wr(i[1:0], d);
			rd(i[1:0], 0, d);
			case (i)
				0: chk("p0_oe", p0e, ~d);
				1: chk("p1", {p1a, p1e}, {d[7:2], ~d[1:0]});
				2: chk("p2_oe", p2e, ~d);
				default: chk("p3_oe", p3e, ~d);
			endcase
		end
		for (int i = 1; i < 4; i++) begin
			m = (i == 1) ? 8'h03 : 8'hff;
			wr(i[1:0], 8'h00);
			cyc(3);
			wr(i[1:0], 8'hff);
			for (int j = 0; j < 3; j++) begin
				cyc(1);
				chk("strong_pu", spu(i), (j < 2) ? m : 8'h00);
			end
		end
		wr(0, 8'hff);
		seed = xs(seed);
		lo = seed;
		cyc(4);
		for (int i = 0; i < 4; i++) begin
			rd(i[1:0], 1, ~lo[8*i+:8]);
			rd(i[1:0], 0, 8'hff);
		end
		chk("t2", {6'h00, t2x, t2c}, {6'h00, ~lo[9:8]});
		chk("p3_alt_in", p3i, ~lo[31:24]);
		wr(1, 8'h00);
		cyc(4);
		chk("t2_zero", {6'h00, t2x, t2c}, 8'h00);
		route = 2'b11;
		for (int k = 0; k < 4; k++) begin
			{pwm_b, pwm_a} = k[1:0];
			cyc(2);
			chk("pwm", {6'h00, p1e}, {6'h00, ~pwm_b, ~pwm_a});
		end
		route = 0;
		seed = xs(seed);
		aen = seed[7:0];
		aout = seed[15:8];
		cyc(2);
		chk("p3_alt", p3e, aen & ~aout);
		wr(3, 8'h00);
		cyc(2);
		chk("p3_stuck", p3e, 8'hff);
		aen = 0;
		seed = xs(seed);
		d = seed[15:8];
		wr(0, seed[7:0]);
		cyc(1);
		wr(2, d);
		ext = {1'b1, seed[23:16], 1'b1, seed[31:24]};
		cyc(1);
		wr(0, 8'h00);
		cyc(2);
		chk("p0_ad", p0o, ext.ad);
		chk("p0_pp", p0e, 8'hff);
		chk("p2_addr", p2o, ext.addr_hi);
		chk("p2_pp", p2e, 8'hff);
		ext.ad_oe = 0;
		lo = xs(seed);
		cyc(5);
		chk("ext_din", exd, ~lo[7:0]);
		ext.active = 0;
		cyc(1);
		rd(0, 0, 8'hff);
		rd(2, 0, d);
		cyc(2);
		summarize();
	end
endmodule : tb_quad_parallel_port_io
